//--- pkg/bct_pkg.sv
// Package of constants and types for the branch and flag-test execution block
package bct_pkg;

  // ****************************************************************
  // Opcodes
  // ****************************************************************
  localparam logic [7:0] OP_BR_NIBBLE_CARRY_SET = 8'h29;
  localparam logic [7:0] OP_BR_UNSIGNED_GREATER = 8'h22;
  localparam logic [7:0] OP_BR_UNSIGNED_NOT_LESS = 8'h24;
  localparam logic [7:0] OP_BR_UNSIGNED_LESS = 8'h25;
  localparam logic [7:0] OP_BR_EXT_INT_HIGH = 8'h2f;
  localparam logic [7:0] OP_BR_EXT_INT_LOW = 8'h2e;
  localparam logic [7:0] OP_BR_SIGNED_NOT_GREATER = 8'h93;
  localparam logic [7:0] OP_AND_TEST_IMM = 8'ha5;
  localparam logic [7:0] OP_AND_TEST_DIR = 8'hb5;
  localparam logic [7:0] OP_AND_TEST_EXT = 8'hc5;
  localparam logic [7:0] OP_AND_TEST_IX2 = 8'hd5;
  localparam logic [7:0] OP_AND_TEST_IX1 = 8'he5;
  localparam logic [7:0] OP_AND_TEST_IX = 8'hf5;
  localparam logic [7:0] OP_PREBYTE = 8'h9e;
  localparam logic [7:0] OP_AND_TEST_SP2 = 8'hd5;
  localparam logic [7:0] OP_AND_TEST_SP1 = 8'he5;

  // ****************************************************************
  // Cycle counts and program counter step
  // ****************************************************************
  localparam logic [2:0] CYC_BRANCH = 3'h3;
  localparam logic [2:0] CYC_IMM = 3'h2;
  localparam logic [2:0] CYC_DIR = 3'h3;
  localparam logic [2:0] CYC_EXT = 3'h4;
  localparam logic [2:0] CYC_IX2 = 3'h4;
  localparam logic [2:0] CYC_IX1 = 3'h3;
  localparam logic [2:0] CYC_IX = 3'h2;
  localparam logic [2:0] CYC_SP2 = 3'h5;
  localparam logic [2:0] CYC_SP1 = 3'h4;
  localparam logic [15:0] PC_BRANCH_STEP = 16'h0002;

  // ****************************************************************
  // Flag positions and reset values
  // ****************************************************************
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_I = 3;
  localparam int FLAG_H = 4;
  localparam int FLAG_V = 7;
  localparam logic [7:0] FLAGS_RESET = 8'h60;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] ACC_RESET = 8'h00;

  typedef struct packed {
    logic       valid;
    logic       prebyte;
    logic [7:0] opcode;
    logic [7:0] operand;
    logic [15:0] pc;
  } bct_instr_t;

  typedef struct packed {
    logic       done;
    logic       taken;
    logic [15:0] next_pc;
    logic [7:0] flags;
  } bct_result_t;

endpackage

//--- rtl/bct_cond.sv
// Branch condition evaluator for the relative branch group
`timescale 1ns/10ps
module bct_cond
  import bct_pkg::*;
(
  input  wire logic [7:0] opcode,
  input  wire logic [7:0] flags,
  input  wire logic       ext_int_pin,
  output logic            is_branch,
  output logic            cond_true
);

  always_comb
  begin
    is_branch = 1'b1;
    cond_true = 1'b0;
    case (opcode)
      OP_BR_NIBBLE_CARRY_SET:   cond_true = flags[FLAG_H];
      OP_BR_UNSIGNED_GREATER:   cond_true = !(flags[FLAG_C] | flags[FLAG_Z]);
      OP_BR_UNSIGNED_NOT_LESS:  cond_true = !flags[FLAG_C];
      OP_BR_EXT_INT_HIGH:       cond_true = ext_int_pin;
      OP_BR_EXT_INT_LOW:        cond_true = !ext_int_pin;
      OP_BR_SIGNED_NOT_GREATER:
        cond_true = flags[FLAG_Z] | (flags[FLAG_N] ^ flags[FLAG_V]);
      OP_BR_UNSIGNED_LESS:      cond_true = flags[FLAG_C];
      default:                  is_branch = 1'b0;
    endcase
  end

endmodule

//--- rtl/bct_exec.sv
// Execution unit for conditional relative branches and the AND flag test
`timescale 1ns/10ps
module bct_exec
  import bct_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  input  wire bct_instr_t  INSTR,
  input  wire logic [7:0]  MEM_OPERAND,
  input  wire logic [7:0]  ACC,
  input  wire logic [7:0]  FLAGS_IN,
  input  wire logic        EXT_INT_PIN,
  output logic             READY,
  output logic             ILLEGAL,
  output bct_result_t      RESULT
);

  // ****************************************************************
  // Types and state
  // ****************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_BUSY} bct_state_t;

  bct_state_t  state_q;
  bct_state_t  state_d;
  logic [2:0]  cnt_q;
  logic [2:0]  cnt_d;
  bct_result_t res_q;
  bct_result_t pend_q;
  bct_result_t pend_d;
  logic        is_branch;
  logic        cond_true;
  logic [2:0]  and_cycles;
  logic        is_and;
  logic        accept;
  logic        is_rel;
  logic        reject;
  logic        last_cycle;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [15:0] branch_target(input logic [15:0] pc, input logic [7:0] rel);
    branch_target = pc + PC_BRANCH_STEP + {{8{rel[7]}}, rel};
  endfunction

  function automatic logic [7:0] and_flags(input logic [7:0] f, input logic [7:0] a,
                                           input logic [7:0] m);
    logic [7:0] r;
    r = a & m;
    and_flags = f;
    and_flags[FLAG_V] = 1'b0;
    and_flags[FLAG_N] = r[7];
    and_flags[FLAG_Z] = (r == 8'h00);
  endfunction

  // ****************************************************************
  // Decode
  // ****************************************************************
  bct_cond u_cond (
    .opcode      (INSTR.opcode),
    .flags       (FLAGS_IN),
    .ext_int_pin (EXT_INT_PIN),
    .is_branch   (is_branch),
    .cond_true   (cond_true)
  );

  always_comb
  begin
    is_and = 1'b1;
    and_cycles = CYC_IMM;
    if (INSTR.prebyte)
    begin
      case (INSTR.opcode)
        OP_AND_TEST_SP2: and_cycles = CYC_SP2;
        OP_AND_TEST_SP1: and_cycles = CYC_SP1;
        default:         is_and = 1'b0;
      endcase
    end
    else
    begin
      case (INSTR.opcode)
        OP_AND_TEST_IMM: and_cycles = CYC_IMM;
        OP_AND_TEST_DIR: and_cycles = CYC_DIR;
        OP_AND_TEST_EXT: and_cycles = CYC_EXT;
        OP_AND_TEST_IX2: and_cycles = CYC_IX2;
        OP_AND_TEST_IX1: and_cycles = CYC_IX1;
        OP_AND_TEST_IX:  and_cycles = CYC_IX;
        default:         is_and = 1'b0;
      endcase
    end
  end

  // ****************************************************************
  // Handshake
  // ****************************************************************
  // Prebyte is never a branch, so gate the branch decode with it
  assign is_rel = is_branch && !INSTR.prebyte;
  assign READY = (state_q == ST_IDLE);
  assign accept = READY && INSTR.valid && (is_rel || is_and);
  assign reject = READY && INSTR.valid && !accept;
  // Shared by the sequencer and the result pulse
  assign last_cycle = (state_q == ST_BUSY) && (cnt_q == 3'h1);

  // ****************************************************************
  // Sequencing
  // ****************************************************************
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    pend_d = pend_q;
    case (state_q)
      ST_IDLE:
      begin
        if (accept)
        begin
          state_d = ST_BUSY;
          pend_d.done = 1'b1;
          if (is_rel)
          begin
            cnt_d = CYC_BRANCH - 3'h1;
            pend_d.taken = cond_true;
            pend_d.flags = FLAGS_IN;
            pend_d.next_pc = cond_true ? branch_target(INSTR.pc, INSTR.operand)
                                       : INSTR.pc + PC_BRANCH_STEP;
          end
          else
          begin
            cnt_d = and_cycles - 3'h1;
            pend_d.taken = 1'b0;
            // Only the flags leave this unit, ACC and memory stay untouched
            pend_d.flags = and_flags(FLAGS_IN, ACC, MEM_OPERAND);
            pend_d.next_pc = INSTR.pc;
          end
        end
      end
      ST_BUSY:
      begin
        cnt_d = cnt_q - 3'h1;
        if (last_cycle)
          state_d = ST_IDLE;
      end
      default:
        state_d = ST_IDLE;
    endcase
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  // Counter holds the cycles still left of the current instruction
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
      cnt_q <= 3'h0;
    else
      cnt_q <= cnt_d;
  end

  // Operands are latched at accept, so later input changes cannot leak in
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
      pend_q <= '{done: 1'b0, taken: 1'b0, next_pc: PC_RESET, flags: FLAGS_RESET};
    else
      pend_q <= pend_d;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Result is a one-cycle pulse, the other fields hold until the next one
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
      res_q <= '{done: 1'b0, taken: 1'b0, next_pc: PC_RESET, flags: FLAGS_RESET};
    else
    begin
      res_q.done <= last_cycle;
      if (last_cycle)
      begin
        res_q.taken <= pend_q.taken;
        res_q.next_pc <= pend_q.next_pc;
        res_q.flags <= pend_q.flags;
      end
    end
  end

  // Unknown opcodes are flagged so the surrounding core can hand them on
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
      ILLEGAL <= 1'b0;
    else
      ILLEGAL <= reject;
  end

  assign RESULT = res_q;

endmodule

//--- test/bct_exec_properties.sv
// Checker for the branch and flag-test unit
`timescale 1ns/10ps
module bct_exec_chk
  import bct_pkg::*;
(
  input wire logic        CORE_CLK,
  input wire logic        RST,
  input wire bct_instr_t  INSTR,
  input wire logic [7:0]  MEM_OPERAND,
  input wire logic [7:0]  ACC,
  input wire logic [7:0]  FLAGS_IN,
  input wire logic        EXT_INT_PIN,
  input wire logic        READY,
  input wire logic        ILLEGAL,
  input wire bct_result_t RESULT
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // Inputs kept from the accepting edge, busy blocks any later accept
  logic [7:0] op_q;
  logic [7:0] f_q;
  logic [7:0] r_q;
  logic       pin_q;
  wire        go = READY && INSTR.valid;
  always_ff @(posedge CORE_CLK or posedge RST)
    if (RST)
      {op_q, f_q, r_q, pin_q} <= '0;
    else if (go)
    begin
      op_q  <= INSTR.opcode;
      f_q   <= FLAGS_IN;
      r_q   <= ACC & MEM_OPERAND;
      pin_q <= EXT_INT_PIN;
    end
  sequence s_done; READY && RESULT.done; endsequence
  property p_br_cyc; go && !INSTR.prebyte
    && INSTR.opcode inside {8'h22, 8'h24, 8'h25, 8'h29, 8'h2e, 8'h2f, 8'h93}
    |=> !READY [*2] ##1 s_done; endproperty
  a_br_cyc: assert property (p_br_cyc) else $error("branch timing");
  property p_and_cyc; go && !INSTR.prebyte && INSTR.opcode == 8'ha5
    |=> !READY [*1] ##1 s_done; endproperty
  a_and_cyc: assert property (p_and_cyc) else $error("test timing");
  property p_nib; RESULT.done && op_q == 8'h29 |-> RESULT.taken == f_q[4]; endproperty
  a_nib: assert property (p_nib) else $error("nibble branch");
  property p_ugt; RESULT.done && op_q == 8'h22 |-> RESULT.taken == !(f_q[0] || f_q[1]);
  endproperty
  a_ugt: assert property (p_ugt) else $error("greater branch");
  property p_carry; RESULT.done && op_q[7:1] == 7'h12 |-> RESULT.taken == (f_q[0] == op_q[0]);
  endproperty
  a_carry: assert property (p_carry) else $error("carry branch");
  property p_pin; RESULT.done && op_q[7:1] == 7'h17 |-> RESULT.taken == (pin_q == op_q[0]);
  endproperty
  a_pin: assert property (p_pin) else $error("pin branch");
  property p_sle; RESULT.done && op_q == 8'h93
    |-> RESULT.taken == (f_q[1] || (f_q[2] != f_q[7])); endproperty
  a_sle: assert property (p_sle) else $error("signed branch");
  property p_keep; RESULT.done && op_q[7:4] == 4'h2 |-> RESULT.flags == f_q; endproperty
  a_keep: assert property (p_keep) else $error("branch flags");
  property p_and; RESULT.done && op_q[3:0] == 4'h5 && op_q[7:4] > 4'h9
    |-> RESULT.flags == {1'b0, f_q[6:3], r_q[7], r_q == 8'h00, f_q[0]}; endproperty
  a_and: assert property (p_and) else $error("test flags");
endmodule
bind bct_exec bct_exec_chk chk_u (.CORE_CLK(CORE_CLK), .RST(RST), .INSTR(INSTR),
  .MEM_OPERAND(MEM_OPERAND), .ACC(ACC), .FLAGS_IN(FLAGS_IN), .EXT_INT_PIN(EXT_INT_PIN),
  .READY(READY), .ILLEGAL(ILLEGAL), .RESULT(RESULT));

//--- test/bct_exec_tb_top.sv
// Self-checking bench for the branch and flag-test unit
`timescale 1ns/10ps
module bct_exec_tb_top import bct_pkg::*; ;
  logic        core_clk;
  logic        rst;
  bct_instr_t  instr;
  logic [7:0]  mem_op;
  logic [7:0]  acc;
  logic [7:0]  flags_in;
  logic        ext_pin;
  logic        ready;
  logic        illegal;
  bct_result_t result;
  int          fail_count;
  int          comparisons;
  int          n;
  logic        done_seen;
  logic        ill_seen;
  bct_exec dut_u (.CORE_CLK(core_clk), .RST(rst), .INSTR(instr), .MEM_OPERAND(mem_op),
    .ACC(acc), .FLAGS_IN(flags_in), .EXT_INT_PIN(ext_pin), .READY(ready),
    .ILLEGAL(illegal), .RESULT(result));
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic chk_n(input string s, input int e, input int g);
    chk(s, 16'(e), 16'(g));
  endtask
  // Ready and outputs are read at the falling edge, where they have settled
  task automatic issue(input logic p, input logic [7:0] op, o, input logic [15:0] pc);
    instr <= '{1'b1, p, op, o, pc};
    @(negedge core_clk);
    while (ready !== 1'b1)
      @(negedge core_clk);
    @(posedge core_clk);
    instr.valid <= 1'b0;
    n = 0;
    do
    begin
      @(negedge core_clk);
      n++;
    end
    while (result.done !== 1'b1 && illegal !== 1'b1 && n < 9);
    done_seen = result.done;
    ill_seen = illegal;
    @(posedge core_clk);
  endtask
  task automatic t_branch();
    logic [7:0] ops [7] = '{8'h29, 8'h22, 8'h24, 8'h2f, 8'h2e, 8'h93, 8'h25};
    logic [7:0] f;
    logic [7:0] o;
    logic       t;
    for (int k = 0; k < 7; k++)
      for (int i = 0; i < 64; i++)
      begin
        f = {i[4], 2'b11, i[3], 1'b0, i[2:0]};
        o = i[5] ? 8'h80 : 8'h7f;
        case (ops[k])
          8'h29: t = f[4];
          8'h22: t = !(f[0] | f[1]);
          8'h24: t = !f[0];
          8'h2f: t = i[5];
          8'h2e: t = !i[5];
          8'h93: t = f[1] | (f[2] ^ f[7]);
          default: t = f[0];
        endcase
        flags_in <= f;
        ext_pin <= i[5];
        issue(1'b0, ops[k], o, 16'hff80 + 16'(i));
        chk_n("br cycles", 3, n);
        chk("br taken", 16'(t), 16'(result.taken));
        chk("br pc", 16'hff82 + 16'(i) + (t ? {{8{o[7]}}, o} : 16'h0000), result.next_pc);
        chk("br flags", 16'(f), 16'(result.flags));
      end
    $display("branch test done");
  endtask
  task automatic t_and();
    logic [16:0] md [8] = '{{1'b0, 8'ha5, 8'h02}, {1'b0, 8'hb5, 8'h03}, {1'b0, 8'hc5, 8'h04},
      {1'b0, 8'hd5, 8'h04}, {1'b0, 8'he5, 8'h03}, {1'b0, 8'hf5, 8'h02},
      {1'b1, 8'hd5, 8'h05}, {1'b1, 8'he5, 8'h04}};
    logic [23:0] v [3] = '{24'hff80ff, 24'h0ff000, 24'h3c1e60};
    logic [7:0]  r;
    for (int k = 0; k < 8; k++)
      for (int j = 0; j < 3; j++)
      begin
        {acc, mem_op, flags_in} <= v[j];
        r = v[j][23:16] & v[j][15:8];
        issue(md[k][16], md[k][15:8], 8'h5a, 16'h4000);
        chk_n("and cycles", md[k][7:0], n);
        chk("and flags", 16'({1'b0, v[j][6:3], r[7], r == 8'h00, v[j][0]}), 16'(result.flags));
        chk("and pc", 16'h4000, result.next_pc);
      end
    $display("flag test done");
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    results();
  end
  initial
  begin
    rst = 1'b1;
    instr = '0;
    {acc, mem_op, flags_in, ext_pin} = '0;
    repeat (20) @(posedge core_clk);
    chk("reset flags", 16'h0060, 16'(result.flags));
    rst <= 1'b0;
    t_branch();
    t_and();
    issue(1'b0, 8'h90, 8'h00, 16'h1000);
    chk("illegal", 16'h0001, 16'(ill_seen));
    chk("illegal done", 16'h0000, 16'(done_seen));
    $display("illegal test done");
    results();
  end
endmodule
